// ==== shared/hbra_pkg.sv ====
// shared constants for the host bus register access ends
package hbra_pkg;
    localparam int SER_REGS = 16;
    localparam int DMA_REGS = 32;
    localparam int SER_IDX_W = 4;
    localparam int DMA_IDX_W = 5;
    // serial command register fields
    localparam int CMD_PTR_LSB = 0;
    localparam int CMD_CODE_LSB = 3;
    localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
    localparam logic [1:0] SHIFT_LEFT_CODE = 2'h1;
    localparam logic [1:0] SHIFT_RIGHT_CODE = 2'h2;
    // bus configuration register fields
    localparam int BCR_DMA_SHL = 0;
    localparam int BCR_MUX = 1;
    localparam int BCR_WAIT = 2;
    localparam int BCR_IACK_LSB = 3;
    localparam int BCR_LANE_HI = 5;
    localparam logic [7:0] BCR_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // controller register map (AHB-Lite)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_WRITE = 0;
    localparam int CTRL_SECT = 1;
    localparam int CTRL_CHAN = 2;
    localparam int CTRL_MUX = 3;
    localparam int CTRL_ADDR_LSB = 8;
    localparam int CTRL_DATA_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DATA_LSB = 16;
endpackage

// ==== shared/host_bus_if.sv ====
// pins between the host controller and the register device
`timescale 1ns/100ps
`default_nettype none
interface host_bus_if;
    logic ce_n;
    logic as_n;
    logic rd_n;
    logic wr_n;
    logic [15:0] h_ad_out;
    logic h_ad_oe_n;
    logic [15:0] d_ad_out;
    logic d_ad_oe_n;
    logic h_sect_out, h_sect_oe_n, d_sect_out, d_sect_oe_n;
    logic h_chan_out, h_chan_oe_n, d_chan_out, d_chan_oe_n;
    logic [15:0] ad;
    logic sect;
    logic chan;
    // wire levels from the enables, pulled high when nobody drives
    assign ad = !h_ad_oe_n ? h_ad_out : (!d_ad_oe_n ? d_ad_out : 16'hFFFF);
    assign sect = !h_sect_oe_n ? h_sect_out :
                  (!d_sect_oe_n ? d_sect_out : 1'b1);
    assign chan = !h_chan_oe_n ? h_chan_out :
                  (!d_chan_oe_n ? d_chan_out : 1'b1);
    modport host (output ce_n, as_n, rd_n, wr_n, h_ad_out, h_ad_oe_n,
        h_sect_out, h_sect_oe_n, h_chan_out, h_chan_oe_n,
        input ad, sect, chan);
    modport device (input ce_n, as_n, rd_n, wr_n, ad, sect, chan,
        output d_ad_out, d_ad_oe_n, d_sect_out, d_sect_oe_n,
        d_chan_out, d_chan_oe_n);
endinterface
`default_nettype wire

// ==== design/reg_device.sv ====
// device end: register addressing behind chip enable and pointers
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module reg_device
    import hbra_pkg::*;
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    host_bus_if.device bus, // pins to the host
    input wire logic dma_master, // device owns the bus
    input wire logic dma_sect, // section value as master
    input wire logic dma_chan, // channel value as master
    input wire logic [7:0] status_a, // channel A status byte
    input wire logic [7:0] status_b, // channel B status byte
    output logic configured, // bus configuration written
    output logic mux_mode, // multiplexed bus selected
    output logic wait_style, // wait/ready handshake style
    output logic [1:0] iack_style, // acknowledge style
    output logic lane_high, // byte lane selection
    output logic wr_pulse, // one register was written
    output logic wr_sect, // section of that write
    output logic wr_chan, // channel of that write
    output logic [4:0] wr_idx, // register index written
    output logic [7:0] wr_data // byte written
);
    import hbra_pkg::*;

    logic [7:0] ser_mem [2][SER_REGS];
    logic [7:0] dma_mem [DMA_REGS];
    logic [7:0] bcr_reg;
    logic cfg_reg;
    logic [7:0] addr_reg;
    logic [3:0] ser_ptr_reg;
    logic ser_arm_reg;
    logic [4:0] dma_ptr_reg;
    logic dma_arm_reg;
    logic ser_shl_reg;
    logic [15:0] ad_out_reg;
    logic ad_oe_n_reg;
    logic sect_out_reg, sect_oe_n_reg, chan_out_reg, chan_oe_n_reg;
    logic wr_pulse_reg, wr_sect_reg, wr_chan_reg;
    logic [4:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    logic acc, is_wr, is_ser, ch;
    logic [7:0] din;
    logic [3:0] ser_idx;
    logic [4:0] dma_idx, mux_ser, mux_dma;
    logic [7:0] rd_byte;

    // strobes count only under chip enable
    assign acc = !bus.ce_n && (!bus.rd_n || !bus.wr_n);
    assign is_wr = !bus.wr_n;
    assign is_ser = bus.sect;
    assign ch = bus.chan;
    assign din = bus.ad[7:0];

    // multiplexed index from the latched address
    assign mux_ser = ser_shl_reg ? addr_reg[5:1] : addr_reg[4:0];
    assign mux_dma = bcr_reg[BCR_DMA_SHL] ? addr_reg[5:1]
                                          : addr_reg[4:0];

    // effective register index for this access
    always_comb begin
        if (bcr_reg[BCR_MUX]) begin
            ser_idx = mux_ser[3:0];
            dma_idx = mux_dma;
        end else begin
            ser_idx = ser_arm_reg ? ser_ptr_reg : 4'h0;
            dma_idx = dma_arm_reg ? dma_ptr_reg : 5'h00;
        end
    end

    // read byte: status at serial index 0, else stored value
    always_comb begin
        if (is_ser) begin
            if (ser_idx == 4'h0) begin
                rd_byte = ch ? status_a : status_b;
            end else begin
                rd_byte = ser_mem[ch][ser_idx];
            end
        end else begin
            rd_byte = dma_mem[dma_idx];
        end
    end

    // address phase latch for the multiplexed bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 8'h00;
        end else if (!bus.ce_n && !bus.as_n) begin
            addr_reg <= bus.ad[7:0];
        end
    end

    // first write after reset loads the bus configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcr_reg <= BCR_RESET;
            cfg_reg <= 1'b0;
        end else if (acc && is_wr && !cfg_reg) begin
            bcr_reg <= din;
            cfg_reg <= 1'b1;
        end
    end

    // serial pointer, touched only by serial accesses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_ptr_reg <= 4'h0;
            ser_arm_reg <= 1'b0;
        end else if (acc && cfg_reg && is_ser && !bcr_reg[BCR_MUX]) begin
            if (ser_arm_reg) begin
                ser_ptr_reg <= 4'h0;
                ser_arm_reg <= 1'b0;
            end else if (is_wr) begin
                ser_ptr_reg <= {din[CMD_CODE_LSB +: 3] == CMD_POINT_HIGH,
                                din[CMD_PTR_LSB +: 3]};
                ser_arm_reg <= 1'b1;
            end
        end
    end

    // DMA pointer, touched only by DMA accesses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_ptr_reg <= 5'h00;
            dma_arm_reg <= 1'b0;
        end else if (acc && cfg_reg && !is_ser && !bcr_reg[BCR_MUX]) begin
            if (dma_arm_reg) begin
                dma_ptr_reg <= 5'h00;
                dma_arm_reg <= 1'b0;
            end else if (is_wr) begin
                dma_ptr_reg <= din[4:0];
                dma_arm_reg <= 1'b1;
            end
        end
    end

    // serial shift mode from command register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_shl_reg <= 1'b0;
        end else if (acc && cfg_reg && is_wr && is_ser && ~|ser_idx) begin
            if (din[1:0] == SHIFT_LEFT_CODE) begin
                ser_shl_reg <= 1'b1;
            end else if (din[1:0] == SHIFT_RIGHT_CODE) begin
                ser_shl_reg <= 1'b0;
            end
        end
    end

    // serial register store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                for (int i = 0; i < SER_REGS; i++) begin
                    ser_mem[c][i] <= REG_RESET;
                end
            end
        end else if (acc && cfg_reg && is_wr && is_ser) begin
            ser_mem[ch][ser_idx] <= din;
        end
    end

    // DMA register store, index 0 is the command/pointer register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DMA_REGS; i++) begin
                dma_mem[i] <= REG_RESET;
            end
        end else if (acc && cfg_reg && is_wr && !is_ser) begin
            dma_mem[dma_idx] <= din;
        end
    end

    // read data driven for one cycle after the read strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ad_out_reg <= 16'h0000;
            ad_oe_n_reg <= 1'b1;
        end else if (acc && !is_wr) begin
            ad_out_reg <= {rd_byte, rd_byte};
            ad_oe_n_reg <= 1'b0;
        end else begin
            ad_oe_n_reg <= 1'b1;
        end
    end

    // select pins driven only while the device is bus master
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sect_out_reg <= 1'b0;
            chan_out_reg <= 1'b0;
            sect_oe_n_reg <= 1'b1;
            chan_oe_n_reg <= 1'b1;
        end else begin
            sect_out_reg <= dma_sect;
            chan_out_reg <= dma_chan;
            sect_oe_n_reg <= !dma_master;
            chan_oe_n_reg <= !dma_master;
        end
    end

    // write report to the user side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pulse_reg <= 1'b0;
            wr_sect_reg <= 1'b0;
            wr_chan_reg <= 1'b0;
            wr_idx_reg <= 5'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_pulse_reg <= acc && is_wr && cfg_reg;
            if (acc && is_wr && cfg_reg) begin
                wr_sect_reg <= is_ser;
                wr_chan_reg <= ch;
                wr_idx_reg <= is_ser ? {1'b0, ser_idx} : dma_idx;
                wr_data_reg <= din;
            end
        end
    end

    // outputs
    assign bus.d_ad_out = ad_out_reg;
    assign bus.d_ad_oe_n = ad_oe_n_reg;
    assign bus.d_sect_out = sect_out_reg;
    assign bus.d_sect_oe_n = sect_oe_n_reg;
    assign bus.d_chan_out = chan_out_reg;
    assign bus.d_chan_oe_n = chan_oe_n_reg;
    assign configured = cfg_reg;
    assign mux_mode = bcr_reg[BCR_MUX];
    assign wait_style = bcr_reg[BCR_WAIT];
    assign iack_style = bcr_reg[BCR_IACK_LSB +: 2];
    assign lane_high = bcr_reg[BCR_LANE_HI];
    assign wr_pulse = wr_pulse_reg;
    assign wr_sect = wr_sect_reg;
    assign wr_chan = wr_chan_reg;
    assign wr_idx = wr_idx_reg;
    assign wr_data = wr_data_reg;
endmodule
`default_nettype wire

// ==== design/host_ctrl.sv ====
// host end: AHB-Lite controlled bus cycles toward the device
`timescale 1ns/100ps
`default_nettype none
module host_ctrl
    import hbra_pkg::*;
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // ready except while in reset
    output logic hresp, // always OKAY
    host_bus_if.host bus // pins to the device
);
    import hbra_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_STRB = 2'b11,
        ST_CAPT = 2'b10
    } hstate_e;

    hstate_e state_reg;
    logic ap_wr_reg, ap_ctrl_reg, start;
    logic [31:0] rdata_reg;
    logic cmd_wr_reg;
    logic [7:0] cmd_data_reg;
    logic [15:0] rd_val_reg;
    logic ce_n_reg, as_n_reg, rd_n_reg, wr_n_reg;
    logic [15:0] ad_out_reg;
    logic ad_oe_n_reg;
    logic sect_reg, chan_reg, sel_oe_n_reg;
    logic [7:0] data_byte;

    // data byte of the control word; its inverse fills the unused lane
    assign data_byte = hwdata[CTRL_DATA_LSB +: 8];

    // write to control while idle starts one bus cycle
    assign start = ap_wr_reg && ap_ctrl_reg && state_reg == ST_IDLE;

    // address phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_reg <= 1'b0;
            ap_ctrl_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (hready) begin
            ap_wr_reg <= hsel && htrans[1] && hwrite;
            ap_ctrl_reg <= haddr[7:0] == CTRL_OFS;
            if (hsel && htrans[1] && !hwrite) begin
                rdata_reg <= (haddr[7:0] == STAT_OFS) ?
                    {rd_val_reg, 15'h0000, state_reg != ST_IDLE} :
                    32'h0000_0000;
            end
        end
    end

    // bus cycle sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            cmd_wr_reg <= 1'b0;
            cmd_data_reg <= 8'h00;
            rd_val_reg <= 16'h0000;
            ce_n_reg <= 1'b1;
            as_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ad_out_reg <= 16'h0000;
            ad_oe_n_reg <= 1'b1;
            sect_reg <= 1'b0;
            chan_reg <= 1'b0;
            sel_oe_n_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        cmd_wr_reg <= hwdata[CTRL_WRITE];
                        cmd_data_reg <= hwdata[CTRL_DATA_LSB +: 8];
                        ce_n_reg <= 1'b0;
                        sect_reg <= hwdata[CTRL_SECT];
                        chan_reg <= hwdata[CTRL_CHAN];
                        sel_oe_n_reg <= 1'b0;
                        if (hwdata[CTRL_MUX]) begin
                            as_n_reg <= 1'b0;
                            ad_out_reg <= {8'h00, hwdata[CTRL_ADDR_LSB +: 8]};
                            ad_oe_n_reg <= 1'b0;
                            state_reg <= ST_ADDR;
                        end else begin
                            rd_n_reg <= hwdata[CTRL_WRITE];
                            wr_n_reg <= !hwdata[CTRL_WRITE];
                            ad_out_reg <= {~data_byte, data_byte};
                            ad_oe_n_reg <= !hwdata[CTRL_WRITE];
                            state_reg <= ST_STRB;
                        end
                    end
                end
                ST_ADDR: begin
                    as_n_reg <= 1'b1;
                    rd_n_reg <= cmd_wr_reg;
                    wr_n_reg <= !cmd_wr_reg;
                    ad_out_reg <= {~cmd_data_reg, cmd_data_reg};
                    ad_oe_n_reg <= !cmd_wr_reg;
                    state_reg <= ST_STRB;
                end
                ST_STRB: begin
                    rd_n_reg <= 1'b1;
                    wr_n_reg <= 1'b1;
                    ad_oe_n_reg <= 1'b1;
                    if (cmd_wr_reg) begin
                        ce_n_reg <= 1'b1;
                        sel_oe_n_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_CAPT;
                    end
                end
                ST_CAPT: begin
                    rd_val_reg <= bus.ad;
                    ce_n_reg <= 1'b1;
                    sel_oe_n_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // outputs
    assign hrdata = rdata_reg;
    assign hreadyout = hresetn;
    assign hresp = 1'b0;
    assign bus.ce_n = ce_n_reg;
    assign bus.as_n = as_n_reg;
    assign bus.rd_n = rd_n_reg;
    assign bus.wr_n = wr_n_reg;
    assign bus.h_ad_out = ad_out_reg;
    assign bus.h_ad_oe_n = ad_oe_n_reg;
    assign bus.h_sect_out = sect_reg;
    assign bus.h_sect_oe_n = sel_oe_n_reg;
    assign bus.h_chan_out = chan_reg;
    assign bus.h_chan_oe_n = sel_oe_n_reg;
endmodule
`default_nettype wire

// ==== sim/hbra_link_assertions.sv ====
// concurrent checks on the host-to-device link
`timescale 1ns/100ps
`default_nettype none
module hbra_link_assertions (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low
    input wire logic ce_n, // chip enable
    input wire logic as_n, // address strobe
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    input wire logic h_ad_oe_n, // host drives ad
    input wire logic [15:0] d_ad_out, // device data
    input wire logic d_ad_oe_n, // device drives ad
    input wire logic d_sect_oe_n, // device drives sect
    input wire logic d_chan_oe_n, // device drives chan
    input wire logic sect, // section level
    input wire logic chan // channel level
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a read strobe and the one-cycle answer it earns
    sequence read_strobe;
        !ce_n && !rd_n;
    endsequence
    sequence answer_pulse;
        !d_ad_oe_n ##1 d_ad_oe_n;
    endsequence
    // answer timing and content
    a_read_answer: assert property (read_strobe |=> answer_pulse)
        else $error("read strobe not answered for one cycle");
    a_answer_cause: assert property ($fell(d_ad_oe_n) |->
        !$past(ce_n) && !$past(rd_n))
        else $error("device drove data without a read strobe");
    a_answer_in_ce: assert property (!d_ad_oe_n |-> !ce_n)
        else $error("device drove data without chip enable");
    a_byte_copy: assert property (!d_ad_oe_n |->
        d_ad_out[15:8] == d_ad_out[7:0])
        else $error("read byte not copied to upper lane");
    a_no_clash: assert property (!h_ad_oe_n |-> d_ad_oe_n)
        else $error("both ends drive the data lines");
    a_sel_input: assert property (!ce_n |->
        d_sect_oe_n && d_chan_oe_n)
        else $error("device drove selects while addressed");
    // strobe framing on the host side
    a_strobe_in_ce: assert property (!rd_n || !wr_n |-> !ce_n)
        else $error("strobe outside chip enable");
    a_strobe_pulse: assert property (!rd_n || !wr_n |=>
        rd_n && wr_n)
        else $error("strobe longer than one cycle");
    a_sel_steady: assert property (!ce_n && !$fell(ce_n) |->
        $stable(sect) && $stable(chan))
        else $error("selects moved inside an access");
    a_addr_phase: assert property (!as_n |->
        !ce_n && !h_ad_oe_n && rd_n && wr_n)
        else $error("address strobe without address on bus");
    c_mux_cycle: cover property (!as_n);
endmodule
`default_nettype wire

// ==== sim/host_bus_register_access_bench.sv ====
// testbench: AHB-Lite driven host end facing the register device end
`timescale 1ns/100ps
`default_nettype none
module host_bus_register_access_bench;
    import hbra_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rnd;
    logic [1:0] htrans;
    logic dma_master, dma_sect, dma_chan, armed, c;
    logic [7:0] status_a, status_b, cfg_byte, d;
    logic configured, mux_mode, wait_style, lane_high, wr_pulse;
    logic [1:0] iack_style;
    logic wr_sect, wr_chan;
    logic [4:0] wr_idx, j;
    logic [7:0] wr_data;
    logic [3:0] k;
    logic [15:0] wq[$];
    logic [15:0] rq[$];
    logic [15:0] mon_exp;
    int n_fail, cmp_count, cyc;
    host_bus_if bus_link();
    host_ctrl host_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bus(bus_link.host));
    reg_device reg_device_inst (.hclk(hclk), .hresetn(hresetn),
        .bus(bus_link.device), .dma_master(dma_master),
        .dma_sect(dma_sect), .dma_chan(dma_chan), .status_a(status_a),
        .status_b(status_b), .configured(configured), .mux_mode(mux_mode),
        .wait_style(wait_style), .iack_style(iack_style),
        .lane_high(lane_high), .wr_pulse(wr_pulse), .wr_sect(wr_sect),
        .wr_chan(wr_chan), .wr_idx(wr_idx), .wr_data(wr_data));
    hbra_link_assertions hbra_link_assertions_inst (.hclk(hclk),
        .hresetn(hresetn), .ce_n(bus_link.ce_n), .as_n(bus_link.as_n),
        .rd_n(bus_link.rd_n), .wr_n(bus_link.wr_n),
        .h_ad_oe_n(bus_link.h_ad_oe_n), .d_ad_out(bus_link.d_ad_out),
        .d_ad_oe_n(bus_link.d_ad_oe_n), .d_sect_oe_n(bus_link.d_sect_oe_n),
        .d_chan_oe_n(bus_link.d_chan_oe_n), .sect(bus_link.sect),
        .chan(bus_link.chan));
    // clock generation
    always #10 hclk = ~hclk;
    // random source
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // comparison and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one AHB-Lite single word transfer
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] dw, output logic [31:0] q);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dw;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // one link access ordered through the control word, then polled
    task automatic xfer(input logic w, s, ch, m, input logic [7:0] a, dv,
        output logic [15:0] r);
        logic [31:0] st;
        ahb(1'b1, CTRL_OFS, {8'h00, dv, a, 4'h0, m, ch, s, w}, st);
        do ahb(1'b0, STAT_OFS, 32'h0, st); while (st[STAT_BUSY] !== 1'b0);
        r = st[31:16];
    endtask
    task automatic wx(input logic s, ch, m, input logic [7:0] a, dv,
        input logic [4:0] idx);
        logic [15:0] r;
        if (idx != 5'h0) begin
            wq.push_back({1'b0, s, s & ch, idx, dv});
        end
        xfer(1'b1, s, ch, m, a, dv, r);
    endtask
    task automatic rx(input logic s, ch, m, input logic [7:0] a, b);
        logic [15:0] r;
        rq.push_back({b, b});
        xfer(1'b0, s, ch, m, a, 8'h00, r);
        check(r, {b, b});
    endtask
    // reset, then the first write sets the bus configuration
    task automatic restart(input logic [1:0] mode);
        logic [15:0] r;
        armed = 1'b0;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rnd = xs(rnd);
        cfg_byte = (rnd[7:0] & 8'h3C) | {6'h0, mode};
        xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, cfg_byte, r);
        check({10'h0, lane_high, iack_style, wait_style, mux_mode,
            configured}, {10'h0, cfg_byte[5:1], 1'b1});
        armed = 1'b1;
    endtask
    // watcher: register writes and read answers against the notes
    always @(posedge hclk) begin
        if (armed && wr_pulse === 1'b1 && wr_idx !== 5'h0) begin
            mon_exp = (wq.size() > 0) ? wq.pop_front() : 16'hFFFF;
            check({1'b0, wr_sect, wr_sect & wr_chan, wr_idx, wr_data},
                mon_exp);
        end
        if (bus_link.d_ad_oe_n === 1'b0 && rq.size() > 0) begin
            check(bus_link.ad, rq.pop_front());
        end
    end
    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    // main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        dma_master = 1'b0;
        dma_sect = 1'b0;
        dma_chan = 1'b0;
        armed = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        rnd = xs(32'h1103);
        status_a = rnd[7:0];
        status_b = rnd[15:8];
        restart(2'b00);
        rx(1'b1, 1'b1, 1'b0, 8'h00, status_a);
        // serial pointer, write, cleared pointer, read back
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            k = rnd[3:0];
            if (i == 0) k = 4'hF;
            if (i == 1) k = 4'h8;
            if (k == 4'h0) k = 4'h9;
            c = rnd[4];
            d = rnd[15:8];
            wx(1'b1, c, 1'b0, 8'h00, {4'h0, k}, 5'h0);
            wx(1'b1, c, 1'b0, 8'h00, d, {1'b0, k});
            rx(1'b1, c, 1'b0, 8'h00, c ? status_a : status_b);
            wx(1'b1, c, 1'b0, 8'h00, {4'h0, k}, 5'h0);
            rx(1'b1, c, 1'b0, 8'h00, d);
        end
        // DMA pointer sequences interleaved with a pending serial pointer
        for (int i = 0; i < 3; i++) begin
            rnd = xs(rnd);
            j = rnd[20:16];
            if (i == 0) j = 5'h1F;
            if (j == 5'h0) j = 5'h10;
            k = (rnd[11:8] == 4'h0) ? 4'h3 : rnd[11:8];
            d = rnd[31:24];
            wx(1'b1, 1'b1, 1'b0, 8'h00, {4'h0, k}, 5'h0);
            wx(1'b0, rnd[5], 1'b0, 8'h00, {3'h0, j}, 5'h0);
            wx(1'b0, rnd[6], 1'b0, 8'h00, d, j);
            wx(1'b1, 1'b1, 1'b0, 8'h00, ~d, {1'b0, k});
        end
        // device as bus master drives the select pins
        dma_sect <= rnd[0];
        dma_chan <= rnd[1];
        dma_master <= 1'b1;
        repeat (3) @(posedge hclk);
        check({13'h0, bus_link.d_sect_oe_n, bus_link.d_sect_out,
            bus_link.d_chan_out}, {14'h0, rnd[0], rnd[1]});
        dma_master <= 1'b0;
        repeat (3) @(posedge hclk);
        check({14'h0, bus_link.d_sect_oe_n, bus_link.d_chan_oe_n},
            16'h0003);
        // multiplexed mode, both DMA shift settings
        for (int p = 0; p < 2; p++) begin
            restart({1'b1, p[0]});
            rnd = xs(rnd);
            k = (rnd[3:0] == 4'h0) ? 4'h5 : rnd[3:0];
            j = (rnd[8:4] == 5'h0) ? 5'h1F : rnd[8:4];
            c = rnd[9];
            d = rnd[23:16];
            wx(1'b1, c, 1'b1, {3'h7, 1'b0, k}, d, {1'b0, k});
            wx(1'b1, c, 1'b1, 8'hE0, 8'h01, 5'h0);
            wx(1'b1, c, 1'b1, {2'h3, 1'b0, k, 1'b1}, ~d, {1'b0, k});
            wx(1'b0, c, 1'b1, p[0] ? {2'h3, j, 1'b1} : {3'h7, j}, d,
                j);
            rx(1'b1, c, 1'b1, 8'hC1, c ? status_a : status_b);
            wx(1'b1, c, 1'b1, 8'hE0, 8'h02, 5'h0);
            wx(1'b1, c, 1'b1, {3'h7, 1'b0, k}, d, {1'b0, k});
        end
        repeat (5) @(posedge hclk);
        check(16'(wq.size()), 16'h0000);
        check(16'(rq.size()), 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
